// [dv/dvis_chk.sv]
// Checker on the sequencer pins: protection, polarity, serial apply, bus timing.
// Assumes binding into dvis_top, one clock domain with reset rst_i.
`timescale 1ns/10ps
`default_nettype none
module dvis_chk (
	input wire clk_i,
	input wire rst_i,
	input wire polarity_invert_i,
	input wire test_force_mode_i,
	input wire serial_load_enable_i,
	input wire thermal_trip_i,
	input wire polarity_invert_o,
	input wire output_mode_o,
	input wire current_limit_en_o,
	input wire amp_enable_o,
	input wire [7:0] dac1_code_o,
	input wire [7:0] dac2_code_o,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Protection, amplifier and polarity outputs
	property p_force; test_force_mode_i |=> current_limit_en_o && !output_mode_o; endproperty
	a_force: assert property (p_force) else $error("force ignored");
	property p_amp;
		!$past(rst_i) |-> amp_enable_o == !(current_limit_en_o && $past(thermal_trip_i));
	endproperty
	a_amp: assert property (p_amp) else $error("amp enable wrong");
	property p_cool; !thermal_trip_i [*2] |=> amp_enable_o; endproperty
	a_cool: assert property (p_cool) else $error("amp not restored");
	property p_pol; !$past(rst_i) |-> polarity_invert_o == $past(polarity_invert_i); endproperty
	a_pol: assert property (p_pol) else $error("polarity lag");
	// Serial codes move only once the enable is back high
	property p_ser;
		$changed(dac1_code_o) || $changed(dac2_code_o) |->
			serial_load_enable_i && $past(serial_load_enable_i);
	endproperty
	a_ser: assert property (p_ser) else $error("dac moved early");
	// Bus answer timing
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; $rose(wb_ack_o) |=> $fell(wb_ack_o); endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_idle; !wb_stb_i |=> !wb_ack_o; endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	c_bus: cover property (wb_ack_o && wb_cyc_i);
	c_trip: cover property (test_force_mode_i && thermal_trip_i);
	c_apply: cover property ($rose(serial_load_enable_i));
endmodule // dvis_chk
bind dvis_top dvis_chk dvis_chk_inst (.clk_i, .rst_i, .polarity_invert_i, .test_force_mode_i,
	.serial_load_enable_i, .thermal_trip_i, .polarity_invert_o, .output_mode_o,
	.current_limit_en_o, .amp_enable_o, .dac1_code_o, .dac2_code_o, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o);
`default_nettype wire

// [dv/dvis_panel.sv]
// Panel timing controller model: pixel clock, words, start and transfer.
// Assumes callers sit on a clk_i edge; each panel level lasts two cycles.
`timescale 1ns/10ps
`default_nettype none
module dvis_panel (
	input wire clk_i,
	output logic pclk_o,
	output logic [9:0] word_o,
	output logic start_o,
	output logic dir_o,
	output logic xfer_o
);
	// Idle state: panel clock low, strobes low
	initial begin
		pclk_o = 1'b0;
		word_o = 10'h000;
		start_o = 1'b0;
		dir_o = 1'b0;
		xfer_o = 1'b0;
	end
	// One panel clock level carrying word w, bit 9 first in weight
	task automatic half(input logic [9:0] w, input logic s, input logic x);
		@(posedge clk_i);
		pclk_o <= ~pclk_o;
		word_o <= w;
		start_o <= s;
		xfer_o <= x;
		@(posedge clk_i);
	endtask
	// Start at one rise, then twelve words from the next rise on
	task automatic frame(input logic d, input logic [9:0] b);
		dir_o <= d;
		half(~b, 1'b1, 1'b0);
		half(b ^ 10'h2aa, 1'b0, 1'b0);
		for (int i = 0; i < 12; i++)
			half(b + 10'(i), 1'b0, 1'b0);
	endtask
	// Transfer seen at the first rise, junk words meanwhile
	task automatic transfer();
		for (int i = 0; i < 6; i++)
			half(~word_o, 1'b0, i == 0);
	endtask
endmodule // dvis_panel
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench: panel frames, serial settings, protection, registers.
// Assumes dvis_top, the panel model and the bound pin checker.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk = 1'b0, sload = 1'b1, sdat = 1'b0, trip = 1'b0, frc = 1'b0, pol = 1'b0;
	logic cyc = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [119:0] exp_ch = 120'h0;
	wire pclk, start, dir, xfer, polo, mode, clim, amp, ack;
	wire [9:0] word;
	wire [119:0] chan;
	wire [7:0] d1, d2;
	wire [31:0] rd;
	int err_count = 0, checked = 0;
	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	dvis_panel dvis_panel_inst (.clk_i, .pclk_o(pclk), .word_o(word), .start_o(start),
		.dir_o(dir), .xfer_o(xfer));
	dvis_top dvis_top_inst (.clk_i, .rst_i, .pixel_clock_i(pclk), .pixel_word_in_i(word),
		.sequence_start_i(start), .right_left_i(dir), .output_transfer_i(xfer),
		.polarity_invert_i(pol), .test_force_mode_i(frc), .serial_clock_i(sclk),
		.serial_load_enable_i(sload), .serial_data_in_i(sdat), .thermal_trip_i(trip),
		.channel_outputs_o(chan), .polarity_invert_o(polo), .output_mode_o(mode),
		.current_limit_en_o(clim), .amp_enable_o(amp), .dac1_code_o(d1), .dac2_code_o(d2),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'hf), .wb_dat_o(rd), .wb_ack_o(ack));
	task chk(input string n, input logic [119:0] e, input logic [119:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Classic single cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (ack !== 1'b1) begin
			err_count++;
			$display("[FAIL] ack expected 1 seen %b", ack);
		end
		rdat = rd;
		cyc <= 1'b0;
	endtask
	// Serial word, first n bits MSB first, applied when the enable rises if n is 12
	task ser(input logic [11:0] w, input int n);
		@(posedge clk_i);
		sload <= 1'b0;
		for (int i = 11; i > 11 - n; i--) begin
			@(posedge clk_i);
			sdat <= w[i];
			@(posedge clk_i);
			sclk <= 1'b1;
			repeat (2) @(posedge clk_i);
			sclk <= 1'b0;
		end
		@(posedge clk_i);
		sdat <= ~sdat;
		sload <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask
	task t_reset;
		chk("outs", {4'b1100, 16'h0000}, {clim, amp, mode, polo, d1, d2});
		wb(1'b0, 8'h04, 32'h0);
		chk("config", 32'h1, rdat);
		wb(1'b0, 8'h00, 32'h0);
		chk("status", 32'h5, rdat);
		wb(1'b1, 8'h08, 32'hffff);
		wb(1'b0, 8'h08, 32'h0);
		chk("serial", 32'h10000, rdat);
		wb(1'b0, 8'h44, 32'h0);
		chk("unmapped", 32'h0, rdat);
	endtask
	task t_frame(input logic d, input logic [9:0] b, input logic c);
		logic [119:0] e;
		e = exp_ch;
		for (int i = 0; i < 12; i++)
			e[10 * (d ? 11 - i : i) +: 10] = b + 10'(i);
		dvis_panel_inst.frame(d, b);
		chk("held", exp_ch, chan);
		dvis_panel_inst.transfer();
		if (c)
			exp_ch = e;
		chk("chan", exp_ch, chan);
	endtask
	task t_capen;
		wb(1'b1, 8'h04, 32'h0);
		t_frame(1'b0, 10'h0aa, 1'b0);
		wb(1'b1, 8'h04, 32'h1);
		wb(1'b0, 8'h3c, 32'h0);
		chk("ch11", exp_ch[119:110], rdat);
	endtask
	task t_serial;
		ser({4'h1, 8'ha5}, 12);
		ser({4'h2, 8'h3c}, 12);
		ser({4'h1, 8'h00}, 11);
		ser({4'h7, 8'hff}, 12);
		chk("dacs", 16'ha53c, {d1, d2});
		wb(1'b0, 8'h08, 32'h0);
		chk("serreg", 32'h13ca5, rdat);
	endtask
	task t_prot;
		ser({4'h0, 8'h02}, 12);
		trip <= 1'b1;
		pol <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("off", 4'b0111, {clim, amp, mode, polo});
		frc <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("forced", 3'b100, {clim, amp, mode});
		trip <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("cool", 3'b110, {clim, amp, mode});
		frc <= 1'b0;
		ser({4'h0, 8'h01}, 12);
		trip <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("trip", 3'b100, {clim, amp, mode});
		trip <= 1'b0;
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_frame(1'b0, 10'h3f8, 1'b1);
		t_frame(1'b1, 10'h155, 1'b1);
		t_capen;
		t_serial;
		t_prot;
		print_verdict;
	end
	// Watchdog, well beyond the expected run
	initial begin
		#400000;
		err_count++;
		print_verdict;
	end
endmodule // tb
`default_nettype wire

// [hdl/dvis_edge.v]
// Edge finder for an input that is already synchronous to clk_i.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module dvis_edge (
	input wire clk_i,
	input wire rst_i,
	input wire sig_i,
	output wire rise_o,
	output wire fall_o
);
	reg last_q;

	// Previous level of the watched input
	always @(posedge clk_i) begin
		// Reset loads the live level so a pin idling high shows no false edge
		if (rst_i) begin
			last_q <= sig_i;
		end else begin
			last_q <= sig_i;
		end
	end

	// Edge pulses last one cycle
	assign rise_o = sig_i & ~last_q;
	assign fall_o = ~sig_i & last_q;
endmodule // dvis_edge

`default_nettype wire

// [hdl/dvis_regs.vh]
// Constants for the decimating video input sequencer: register map,
// field positions, reset values and serial function codes.
// Assumes inclusion by bare name from the design files.
`ifndef DVIS_REGS_VH
`define DVIS_REGS_VH

// Pixel word and channel layout
`define DVIS_PIX_W 10
`define DVIS_NUM_CH 12
`define DVIS_CH_FIRST 4'h0
`define DVIS_CH_LAST 4'hb

// Serial word layout
`define DVIS_SER_BITS 4'hc
`define DVIS_SER_FN_MSB 11
`define DVIS_SER_FN_LSB 8
`define DVIS_FN_CTRL 4'h0
`define DVIS_FN_DAC1 4'h1
`define DVIS_FN_DAC2 4'h2
`define DVIS_CTRL_PROT_BIT 0
`define DVIS_CTRL_MODE_BIT 1

// Register byte offsets
`define DVIS_REG_STATUS 8'h00
`define DVIS_REG_CONFIG 8'h04
`define DVIS_REG_SERIAL 8'h08
`define DVIS_REG_CH_BASE 8'h10
`define DVIS_REG_CH_END 8'h3c

// Field positions
`define DVIS_CFG_CAPEN_BIT 0
`define DVIS_ST_PROT_BIT 0
`define DVIS_ST_MODE_BIT 1
`define DVIS_ST_AMP_BIT 2
`define DVIS_ST_ACTIVE_BIT 3
`define DVIS_ST_DIR_BIT 4
`define DVIS_ST_CH_LSB 8

// Reset values
`define DVIS_RST_PROT 1'b1
`define DVIS_RST_MODE 1'b0
`define DVIS_RST_CAPEN 1'b1
`define DVIS_RST_DAC 8'h00

`endif

// [hdl/dvis_top.v]
// Digital front end of a twelve-channel decimating column driver: pixel
// capture on both edges of the panel clock, channel steering, transfer to
// the output stage, serial settings port, protection control, Wishbone slave.
// Assumes all pins are synchronous to clk_i and the panel clock is well
// below half of clk_i, so each of its edges is seen as a separate cycle.
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dvis_regs.vh"

// Notes on behaviour
// - Pixel word is ten bits, bit nine MSB.
// - Capture a word on both panel clock edges.
// - Start sampled high begins sequence next rise.
// - Direction low starts channel 0, high channel 11.
// - Transfer sampled high moves words next rise.
// - Polarity input selects output polarity.
// - Serial bit enables limiter and thermal shutdown.
// - Thermal trip disables amplifiers while protection enabled.
// - Test force means protection on, mode normal.
// - Twelve-bit serial word, applied on enable rise.
module dvis_top (
	input wire clk_i,
	input wire rst_i,
	// Panel timing controller side
	input wire pixel_clock_i,
	input wire [9:0] pixel_word_in_i,
	input wire sequence_start_i,
	input wire right_left_i,
	input wire output_transfer_i,
	input wire polarity_invert_i,
	input wire test_force_mode_i,
	// Serial settings port
	input wire serial_clock_i,
	input wire serial_load_enable_i,
	input wire serial_data_in_i,
	// Thermal comparator, hysteresis held in the analog sensor
	input wire thermal_trip_i,
	// Output stage side
	output reg [119:0] channel_outputs_o,
	output reg polarity_invert_o,
	output reg output_mode_o,
	output reg current_limit_en_o,
	output reg amp_enable_o,
	output reg [7:0] dac1_code_o,
	output reg [7:0] dac2_code_o,
	// Classic Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o
);
	wire pclk_rise;
	wire pclk_fall;
	wire sclk_rise;
	wire sen_rise;
	wire sen_fall;

	// Channel latches, loaded one word at a time
	reg [9:0] latch_q [0:11];
	reg start_pend_q;
	reg xfer_pend_q;
	reg active_q;
	reg dir_q;
	reg [3:0] ch_q;
	reg [3:0] left_q;
	// Serial port state
	reg [11:0] ser_shift_q;
	reg [3:0] ser_cnt_q;
	reg prot_reg_q;
	reg mode_reg_q;
	// Configuration written by software
	reg capen_q;
	wire prot_eff;
	wire mode_eff;
	wire wb_req;
	wire [7:0] ch_rel;
	wire [3:0] ch_idx;
	integer i;
	integer k;

	// Panel clock edges
	dvis_edge u_pclk (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sig_i(pixel_clock_i),
		.rise_o(pclk_rise),
		.fall_o(pclk_fall)
	);

	// Serial clock edges
	dvis_edge u_sclk (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sig_i(serial_clock_i),
		.rise_o(sclk_rise),
		.fall_o()
	);

	// Serial enable edges
	dvis_edge u_sen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sig_i(serial_load_enable_i),
		.rise_o(sen_rise),
		.fall_o(sen_fall)
	);

	// Sequencing of the loading run and the pending strobes
	always @(posedge clk_i) begin
		if (rst_i) begin
			start_pend_q <= 1'b0;
			xfer_pend_q <= 1'b0;
			active_q <= 1'b0;
			dir_q <= 1'b0;
			ch_q <= `DVIS_CH_FIRST;
			left_q <= 4'h0;
		end else begin
			if (pclk_rise) begin
				start_pend_q <= sequence_start_i;
				xfer_pend_q <= output_transfer_i;
			end
			if (pclk_rise && start_pend_q && capen_q) begin
				// First word of a new run goes to the chosen end
				dir_q <= right_left_i;
				ch_q <= right_left_i ? (`DVIS_CH_LAST - 4'h1) : (`DVIS_CH_FIRST + 4'h1);
				left_q <= `DVIS_CH_LAST;
				active_q <= 1'b1;
			end else if ((pclk_rise || pclk_fall) && active_q) begin
				// Each further edge steps to the adjacent channel
				ch_q <= dir_q ? (ch_q - 4'h1) : (ch_q + 4'h1);
				left_q <= left_q - 4'h1;
				if (left_q == 4'h1) begin
					active_q <= 1'b0;
				end
			end
		end
	end

	// Word capture into the channel latches on either panel clock edge
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < `DVIS_NUM_CH; i = i + 1) begin
				latch_q[i] <= 10'h000;
			end
		end else if (pclk_rise && start_pend_q && capen_q) begin
			if (right_left_i) begin
				latch_q[`DVIS_CH_LAST] <= pixel_word_in_i;
			end else begin
				latch_q[`DVIS_CH_FIRST] <= pixel_word_in_i;
			end
		end else if ((pclk_rise || pclk_fall) && active_q) begin
			latch_q[ch_q] <= pixel_word_in_i;
		end
	end

	// Output stage: all latches move together on the rise after transfer
	always @(posedge clk_i) begin
		if (rst_i) begin
			channel_outputs_o <= 120'h0;
			polarity_invert_o <= 1'b0;
		end else begin
			polarity_invert_o <= polarity_invert_i;
			if (pclk_rise && xfer_pend_q) begin
				for (k = 0; k < `DVIS_NUM_CH; k = k + 1) begin
					channel_outputs_o[k*10 +: 10] <= latch_q[k];
				end
			end
		end
	end

	// Serial shift register, MSB first, loads only while enable is low
	always @(posedge clk_i) begin
		if (rst_i) begin
			ser_shift_q <= 12'h000;
			ser_cnt_q <= 4'h0;
		end else if (sen_fall) begin
			ser_cnt_q <= 4'h0;
		end else if (sclk_rise && !serial_load_enable_i) begin
			ser_shift_q <= {ser_shift_q[10:0], serial_data_in_i};
			if (ser_cnt_q != `DVIS_SER_BITS) begin
				ser_cnt_q <= ser_cnt_q + 4'h1;
			end
		end
	end

	// Settings applied on the enable rising edge, only after a full word
	always @(posedge clk_i) begin
		if (rst_i) begin
			prot_reg_q <= `DVIS_RST_PROT;
			mode_reg_q <= `DVIS_RST_MODE;
			dac1_code_o <= `DVIS_RST_DAC;
			dac2_code_o <= `DVIS_RST_DAC;
		end else if (sen_rise && ser_cnt_q == `DVIS_SER_BITS) begin
			case (ser_shift_q[`DVIS_SER_FN_MSB:`DVIS_SER_FN_LSB])
				`DVIS_FN_CTRL: begin
					prot_reg_q <= ser_shift_q[`DVIS_CTRL_PROT_BIT];
					mode_reg_q <= ser_shift_q[`DVIS_CTRL_MODE_BIT];
				end
				`DVIS_FN_DAC1: begin
					dac1_code_o <= ser_shift_q[7:0];
				end
				`DVIS_FN_DAC2: begin
					dac2_code_o <= ser_shift_q[7:0];
				end
				default: begin
					prot_reg_q <= prot_reg_q;
				end
			endcase
		end
	end

	// Test force overrides the programmed protection and mode
	assign prot_eff = test_force_mode_i | prot_reg_q;
	assign mode_eff = test_force_mode_i ? 1'b0 : mode_reg_q;

	// Protection outputs: limiter and thermal shutdown act only when enabled
	always @(posedge clk_i) begin
		if (rst_i) begin
			current_limit_en_o <= `DVIS_RST_PROT;
			amp_enable_o <= 1'b1;
			output_mode_o <= `DVIS_RST_MODE;
		end else begin
			current_limit_en_o <= prot_eff;
			amp_enable_o <= ~(prot_eff & thermal_trip_i);
			output_mode_o <= mode_eff;
		end
	end

	// Wishbone decode
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign ch_rel = wb_adr_i - `DVIS_REG_CH_BASE;
	assign ch_idx = ch_rel[5:2];

	// Wishbone slave: one wait state, ack for one cycle, unmapped reads zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			capen_q <= `DVIS_RST_CAPEN;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `DVIS_REG_CONFIG) begin
				capen_q <= wb_dat_i[`DVIS_CFG_CAPEN_BIT];
			end
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= 32'h0;
				if (wb_adr_i == `DVIS_REG_STATUS) begin
					wb_dat_o[`DVIS_ST_PROT_BIT] <= prot_eff;
					wb_dat_o[`DVIS_ST_MODE_BIT] <= mode_eff;
					wb_dat_o[`DVIS_ST_AMP_BIT] <= amp_enable_o;
					wb_dat_o[`DVIS_ST_ACTIVE_BIT] <= active_q;
					wb_dat_o[`DVIS_ST_DIR_BIT] <= dir_q;
					wb_dat_o[`DVIS_ST_CH_LSB +: 4] <= ch_q;
				end else if (wb_adr_i == `DVIS_REG_CONFIG) begin
					wb_dat_o[`DVIS_CFG_CAPEN_BIT] <= capen_q;
				end else if (wb_adr_i == `DVIS_REG_SERIAL) begin
					wb_dat_o[15:0] <= {dac2_code_o, dac1_code_o};
					wb_dat_o[16] <= prot_reg_q;
					wb_dat_o[17] <= mode_reg_q;
				end else if (wb_adr_i >= `DVIS_REG_CH_BASE && wb_adr_i <= `DVIS_REG_CH_END
						&& wb_adr_i[1:0] == 2'h0) begin
					wb_dat_o[9:0] <= channel_outputs_o[ch_idx*10 +: 10];
				end
			end
		end
	end
endmodule // dvis_top

`default_nettype wire
